/* File: bcd_defs.vh */
// Opcode, length and timing constants for the byte core opcode decoder.
`ifndef BCD_DEFS_VH
`define BCD_DEFS_VH

// ----------------------------------------------------------------------
// Instruction classes
// ----------------------------------------------------------------------
`define BCD_CLS_ILLEGAL 5'h00
`define BCD_CLS_ADD 5'h01
`define BCD_CLS_ADD_CY 5'h02
`define BCD_CLS_SUB 5'h03
`define BCD_CLS_AND 5'h04
`define BCD_CLS_OR 5'h05
`define BCD_CLS_XOR 5'h06
`define BCD_CLS_ACC_UNARY 5'h07
`define BCD_CLS_MOVE 5'h08
`define BCD_CLS_PTR_LOAD 5'h09
`define BCD_CLS_CODE_READ 5'h0A
`define BCD_CLS_EXT_READ 5'h0B
`define BCD_CLS_EXT_WRITE 5'h0C
`define BCD_CLS_PUSH 5'h0D
`define BCD_CLS_POP 5'h0E
`define BCD_CLS_EXCH 5'h0F
`define BCD_CLS_MUL 5'h10
`define BCD_CLS_DIV 5'h11
`define BCD_CLS_DEC_ADJ 5'h12
`define BCD_CLS_MISC 5'h13

// ----------------------------------------------------------------------
// Operand source codes
// ----------------------------------------------------------------------
`define BCD_SRC_NONE 3'h0
`define BCD_SRC_REG 3'h1
`define BCD_SRC_DIR 3'h2
`define BCD_SRC_IND 3'h3
`define BCD_SRC_IMM 3'h4
`define BCD_SRC_ACC 3'h5

// ----------------------------------------------------------------------
// Destination codes
// ----------------------------------------------------------------------
`define BCD_DST_ACC 3'h0
`define BCD_DST_REG 3'h1
`define BCD_DST_DIR 3'h2
`define BCD_DST_IND 3'h3
`define BCD_DST_PTR 3'h4
`define BCD_DST_EXT 3'h5

// ----------------------------------------------------------------------
// Lengths and cycle counts
// ----------------------------------------------------------------------
`define BCD_LEN_1 2'h1
`define BCD_LEN_2 2'h2
`define BCD_LEN_3 2'h3
`define BCD_CYC_1 3'h1
`define BCD_CYC_2 3'h2
`define BCD_CYC_4 3'h4
`define BCD_CYC_ONE_LEFT 3'h1
`define BCD_BYTES_ZERO 2'h0
`define BCD_BYTES_ONE 2'h1

// ----------------------------------------------------------------------
// Opcode field helpers
// ----------------------------------------------------------------------
`define BCD_RSEL_LSB 0
`define BCD_RSEL_MSB 2
`define BCD_ISEL_BIT 0
`define BCD_RESET_PC 16'h0000
`define BCD_OPC_NOP 8'h00

`endif

/* File: bcd_table.v */
// Opcode decode table: class, source, destination, length and cycles.
`timescale 1ns/1ps
`include "bcd_defs.vh"

module bcd_table (
  opcode,
  cls,
  src,
  dst,
  len,
  cyc,
  legal
);
  input wire [7:0] opcode;
  output reg [4:0] cls;
  output reg [2:0] src;
  output reg [2:0] dst;
  output reg [1:0] len;
  output reg [2:0] cyc;
  output reg legal;

  // --------------------------------------------------------------------
  // Table lookup
  // --------------------------------------------------------------------
  // Each opcode maps to one row; unlisted opcodes are flagged illegal.
  always @* begin
    cls = `BCD_CLS_ILLEGAL;
    src = `BCD_SRC_NONE;
    dst = `BCD_DST_ACC;
    len = `BCD_LEN_1;
    cyc = `BCD_CYC_1;
    legal = 1'b1;
    casez (opcode)
      8'b0010_1???: begin cls = `BCD_CLS_ADD; src = `BCD_SRC_REG; end
      8'h25: begin cls = `BCD_CLS_ADD; src = `BCD_SRC_DIR; len = `BCD_LEN_2; end
      8'b0010_011?: begin cls = `BCD_CLS_ADD; src = `BCD_SRC_IND; end
      8'h24: begin cls = `BCD_CLS_ADD; src = `BCD_SRC_IMM; len = `BCD_LEN_2; end
      8'b0011_1???: begin cls = `BCD_CLS_ADD_CY; src = `BCD_SRC_REG; end
      8'h35: begin cls = `BCD_CLS_ADD_CY; src = `BCD_SRC_DIR; len = `BCD_LEN_2; end
      8'b0011_011?: begin cls = `BCD_CLS_ADD_CY; src = `BCD_SRC_IND; end
      8'h34: begin cls = `BCD_CLS_ADD_CY; src = `BCD_SRC_IMM; len = `BCD_LEN_2; end
      8'b1001_1???: begin cls = `BCD_CLS_SUB; src = `BCD_SRC_REG; end
      8'h95: begin cls = `BCD_CLS_SUB; src = `BCD_SRC_DIR; len = `BCD_LEN_2; end
      8'b1001_011?: begin cls = `BCD_CLS_SUB; src = `BCD_SRC_IND; end
      8'h94: begin cls = `BCD_CLS_SUB; src = `BCD_SRC_IMM; len = `BCD_LEN_2; end
      8'b0101_1???: begin cls = `BCD_CLS_AND; src = `BCD_SRC_REG; end
      8'h55: begin cls = `BCD_CLS_AND; src = `BCD_SRC_DIR; len = `BCD_LEN_2; end
      8'b0101_011?: begin cls = `BCD_CLS_AND; src = `BCD_SRC_IND; end
      8'h54: begin cls = `BCD_CLS_AND; src = `BCD_SRC_IMM; len = `BCD_LEN_2; end
      8'h52: begin cls = `BCD_CLS_AND; src = `BCD_SRC_ACC; dst = `BCD_DST_DIR; len = `BCD_LEN_2; end
      8'h53: begin
        cls = `BCD_CLS_AND; src = `BCD_SRC_IMM; dst = `BCD_DST_DIR; len = `BCD_LEN_3; cyc = `BCD_CYC_2;
      end
      8'b0100_1???: begin cls = `BCD_CLS_OR; src = `BCD_SRC_REG; end
      8'h45: begin cls = `BCD_CLS_OR; src = `BCD_SRC_DIR; len = `BCD_LEN_2; end
      8'b0100_011?: begin cls = `BCD_CLS_OR; src = `BCD_SRC_IND; end
      8'h44: begin cls = `BCD_CLS_OR; src = `BCD_SRC_IMM; len = `BCD_LEN_2; end
      8'h42: begin cls = `BCD_CLS_OR; src = `BCD_SRC_ACC; dst = `BCD_DST_DIR; len = `BCD_LEN_2; end
      8'h43: begin
        cls = `BCD_CLS_OR; src = `BCD_SRC_IMM; dst = `BCD_DST_DIR; len = `BCD_LEN_3; cyc = `BCD_CYC_2;
      end
      8'b0110_1???: begin cls = `BCD_CLS_XOR; src = `BCD_SRC_REG; end
      8'h65: begin cls = `BCD_CLS_XOR; src = `BCD_SRC_DIR; len = `BCD_LEN_2; end
      8'b0110_011?: begin cls = `BCD_CLS_XOR; src = `BCD_SRC_IND; end
      8'h64: begin cls = `BCD_CLS_XOR; src = `BCD_SRC_IMM; len = `BCD_LEN_2; end
      8'h62: begin cls = `BCD_CLS_XOR; src = `BCD_SRC_ACC; dst = `BCD_DST_DIR; len = `BCD_LEN_2; end
      8'h63: begin
        cls = `BCD_CLS_XOR; src = `BCD_SRC_IMM; dst = `BCD_DST_DIR; len = `BCD_LEN_3; cyc = `BCD_CYC_2;
      end
      8'h23, 8'h33, 8'hE4, 8'hF4, 8'hC4: begin cls = `BCD_CLS_ACC_UNARY; src = `BCD_SRC_ACC; end
      8'h03, 8'h13: begin cls = `BCD_CLS_ACC_UNARY; src = `BCD_SRC_ACC; end
      8'b0111_1???: begin cls = `BCD_CLS_MOVE; src = `BCD_SRC_IMM; dst = `BCD_DST_REG; len = `BCD_LEN_2; end
      8'b1111_1???: begin cls = `BCD_CLS_MOVE; src = `BCD_SRC_ACC; dst = `BCD_DST_REG; end
      8'b1010_1???: begin
        cls = `BCD_CLS_MOVE; src = `BCD_SRC_DIR; dst = `BCD_DST_REG; len = `BCD_LEN_2; cyc = `BCD_CYC_2;
      end
      8'b1000_1???: begin
        cls = `BCD_CLS_MOVE; src = `BCD_SRC_REG; dst = `BCD_DST_DIR; len = `BCD_LEN_2; cyc = `BCD_CYC_2;
      end
      8'h85: begin
        cls = `BCD_CLS_MOVE; src = `BCD_SRC_DIR; dst = `BCD_DST_DIR; len = `BCD_LEN_3; cyc = `BCD_CYC_2;
      end
      8'h75: begin
        cls = `BCD_CLS_MOVE; src = `BCD_SRC_IMM; dst = `BCD_DST_DIR; len = `BCD_LEN_3; cyc = `BCD_CYC_2;
      end
      8'b1010_011?: begin
        cls = `BCD_CLS_MOVE; src = `BCD_SRC_DIR; dst = `BCD_DST_IND; len = `BCD_LEN_2; cyc = `BCD_CYC_2;
      end
      8'b0111_011?: begin cls = `BCD_CLS_MOVE; src = `BCD_SRC_IMM; dst = `BCD_DST_IND; len = `BCD_LEN_2; end
      8'b1111_011?: begin cls = `BCD_CLS_MOVE; src = `BCD_SRC_ACC; dst = `BCD_DST_IND; end
      8'h90: begin
        cls = `BCD_CLS_PTR_LOAD; src = `BCD_SRC_IMM; dst = `BCD_DST_PTR; len = `BCD_LEN_3; cyc = `BCD_CYC_2;
      end
      8'h93: begin cls = `BCD_CLS_CODE_READ; src = `BCD_SRC_ACC; cyc = `BCD_CYC_2; end
      8'hE0: begin cls = `BCD_CLS_EXT_READ; cyc = `BCD_CYC_2; end
      8'hF0: begin cls = `BCD_CLS_EXT_WRITE; src = `BCD_SRC_ACC; dst = `BCD_DST_EXT; cyc = `BCD_CYC_2; end
      8'b1110_001?: begin cls = `BCD_CLS_EXT_READ; src = `BCD_SRC_IND; cyc = `BCD_CYC_2; end
      8'b1111_001?: begin cls = `BCD_CLS_EXT_WRITE; src = `BCD_SRC_ACC; dst = `BCD_DST_EXT; cyc = `BCD_CYC_2; end
      8'hC0: begin cls = `BCD_CLS_PUSH; src = `BCD_SRC_DIR; len = `BCD_LEN_2; cyc = `BCD_CYC_2; end
      8'hD0: begin cls = `BCD_CLS_POP; dst = `BCD_DST_DIR; len = `BCD_LEN_2; cyc = `BCD_CYC_2; end
      8'b1100_1???: begin cls = `BCD_CLS_EXCH; src = `BCD_SRC_REG; end
      8'hC5: begin cls = `BCD_CLS_EXCH; src = `BCD_SRC_DIR; len = `BCD_LEN_2; end
      8'b1100_011?: begin cls = `BCD_CLS_EXCH; src = `BCD_SRC_IND; end
      8'hA4: begin cls = `BCD_CLS_MUL; src = `BCD_SRC_ACC; cyc = `BCD_CYC_4; end
      8'h84: begin cls = `BCD_CLS_DIV; src = `BCD_SRC_ACC; cyc = `BCD_CYC_4; end
      8'hD4: begin cls = `BCD_CLS_DEC_ADJ; src = `BCD_SRC_ACC; end
      // No operation.
      `BCD_OPC_NOP: begin cls = `BCD_CLS_MISC; end
      default: begin legal = 1'b0; end
    endcase
  end

endmodule // bcd_table

/* File: bcd_cnt.v */
// Loadable down counter used for byte fetch and cycle timing.
`timescale 1ns/1ps

module bcd_cnt #(
  parameter W = 3
) (
  clk,
  rst_b,
  load,
  load_val,
  dec,
  count_q
);
  input wire clk;
  input wire rst_b;
  input wire load;
  input wire [W-1:0] load_val;
  input wire dec;
  output reg [W-1:0] count_q;

  // --------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------
  // Load wins over decrement; the counter stops at zero.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= {W{1'b0}};
    end else if (load) begin
      count_q <= load_val;
    end else if (dec && (count_q != {W{1'b0}})) begin
      count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule // bcd_cnt

/* File: bcd_decoder.v */
// Top of the byte core opcode decoder: fetch sequencing and decode outputs.
`timescale 1ns/1ps
`include "bcd_defs.vh"

module bcd_decoder #(
  parameter PC_W = 16
) (
  clk,
  rst_b,
  prog_data,
  prog_valid,
  prog_addr,
  prog_req,
  exec_valid,
  exec_opcode,
  exec_class,
  exec_src,
  exec_dst,
  exec_len,
  exec_cycles,
  exec_reg_sel,
  exec_operand1,
  exec_operand2,
  exec_illegal,
  busy
);
  input wire clk;
  input wire rst_b;
  input wire [7:0] prog_data;
  input wire prog_valid;
  output reg [PC_W-1:0] prog_addr;
  output reg prog_req;
  output reg exec_valid;
  output reg [7:0] exec_opcode;
  output reg [4:0] exec_class;
  output reg [2:0] exec_src;
  output reg [2:0] exec_dst;
  output reg [1:0] exec_len;
  output reg [2:0] exec_cycles;
  output reg [2:0] exec_reg_sel;
  output reg [7:0] exec_operand1;
  output reg [7:0] exec_operand2;
  output reg exec_illegal;
  output reg busy;

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [1:0] ST_OPCODE = 2'b00;
  localparam [1:0] ST_OPERAND = 2'b01;
  localparam [1:0] ST_EXEC = 2'b10;

  reg [1:0] state_q; // Sequencer state.
  reg [1:0] state_d; // Next sequencer state.
  reg [7:0] opc_q; // Opcode being handled.
  reg [1:0] byte_idx_q; // Operand bytes already taken.
  wire [4:0] tbl_cls; // Class from the table.
  wire [2:0] tbl_src; // Source from the table.
  wire [2:0] tbl_dst; // Destination from the table.
  wire [1:0] tbl_len; // Length from the table.
  wire [2:0] tbl_cyc; // Cycle count from the table.
  wire tbl_legal; // Opcode is known.
  wire [1:0] bytes_left; // Operand bytes still to fetch.
  wire [2:0] cyc_left; // Execute cycles still to run.
  wire take_byte; // A program byte is accepted this cycle.
  wire op_load; // Load operand counter.
  wire cyc_load; // Load cycle counter.

  // --------------------------------------------------------------------
  // Decode table and counters
  // --------------------------------------------------------------------
  // The table looks at the byte on the bus while waiting for an opcode,
  // and at the held opcode otherwise.
  bcd_table u_table (
    .opcode((state_q == ST_OPCODE) ? prog_data : opc_q),
    .cls(tbl_cls),
    .src(tbl_src),
    .dst(tbl_dst),
    .len(tbl_len),
    .cyc(tbl_cyc),
    .legal(tbl_legal)
  );

  assign take_byte = prog_req && prog_valid;
  assign op_load = (state_q == ST_OPCODE) && take_byte;
  assign cyc_load = (state_d == ST_EXEC) && (state_q != ST_EXEC);

  // Operand bytes remaining: length less the opcode byte.
  bcd_cnt #(.W(2)) u_op_cnt (
    .clk(clk),
    .rst_b(rst_b),
    .load(op_load),
    .load_val(tbl_len - `BCD_BYTES_ONE),
    .dec((state_q == ST_OPERAND) && take_byte),
    .count_q(bytes_left)
  );

  // Execute cycles remaining for the current instruction.
  bcd_cnt #(.W(3)) u_cyc_cnt (
    .clk(clk),
    .rst_b(rst_b),
    .load(cyc_load),
    .load_val(tbl_cyc),
    .dec(state_q == ST_EXEC),
    .count_q(cyc_left)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  // Opcode, then any operand bytes, then the execute cycles. Illegal
  // opcodes go straight to execute as one cycle with the illegal flag.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OPCODE: begin
        if (take_byte) begin
          if (tbl_legal && (tbl_len != `BCD_LEN_1)) begin
            state_d = ST_OPERAND;
          end else begin
            state_d = ST_EXEC;
          end
        end
      end
      ST_OPERAND: begin
        if (take_byte && (bytes_left == `BCD_BYTES_ONE)) begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (cyc_left == `BCD_CYC_ONE_LEFT) begin
          state_d = ST_OPCODE;
        end
      end
      default: begin
        state_d = ST_OPCODE;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Sequencer registers
  // --------------------------------------------------------------------
  // Holds state, opcode, program address and fetch request.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_OPCODE;
      opc_q <= `BCD_OPC_NOP;
      byte_idx_q <= `BCD_BYTES_ZERO;
      prog_addr <= `BCD_RESET_PC;
      prog_req <= 1'b1;
      busy <= 1'b0;
    end else begin
      state_q <= state_d;
      // Each accepted byte moves the program address on by one.
      if (take_byte) begin
        prog_addr <= prog_addr + {{(PC_W-1){1'b0}}, 1'b1};
      end
      if (op_load) begin
        opc_q <= prog_data;
        byte_idx_q <= `BCD_BYTES_ZERO;
      end else if ((state_q == ST_OPERAND) && take_byte) begin
        byte_idx_q <= byte_idx_q + `BCD_BYTES_ONE;
      end
      // Fetching stops for the execute phase and resumes after it.
      prog_req <= (state_d != ST_EXEC);
      busy <= (state_d != ST_OPCODE);
    end
  end

  // --------------------------------------------------------------------
  // Decode outputs
  // --------------------------------------------------------------------
  // Fields are captured with the opcode and operands, then exec_valid
  // pulses for one cycle at the start of execution.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      exec_valid <= 1'b0;
      exec_opcode <= `BCD_OPC_NOP;
      exec_class <= `BCD_CLS_ILLEGAL;
      exec_src <= `BCD_SRC_NONE;
      exec_dst <= `BCD_DST_ACC;
      exec_len <= `BCD_LEN_1;
      exec_cycles <= `BCD_CYC_1;
      exec_reg_sel <= 3'h0;
      exec_operand1 <= 8'h00;
      exec_operand2 <= 8'h00;
      exec_illegal <= 1'b0;
    end else begin
      exec_valid <= cyc_load;
      if (op_load) begin
        exec_opcode <= prog_data;
        exec_class <= tbl_cls;
        exec_src <= tbl_src;
        exec_dst <= tbl_dst;
        exec_len <= tbl_len;
        exec_cycles <= tbl_cyc;
        // Register and indirect forms alike take bits 2..0 of the opcode.
        exec_reg_sel <= prog_data[`BCD_RSEL_MSB:`BCD_RSEL_LSB];
        exec_illegal <= !tbl_legal;
        exec_operand1 <= 8'h00;
        exec_operand2 <= 8'h00;
      end else if ((state_q == ST_OPERAND) && take_byte) begin
        if (byte_idx_q == `BCD_BYTES_ZERO) begin
          exec_operand1 <= prog_data;
        end else begin
          exec_operand2 <= prog_data;
        end
      end
    end
  end

endmodule // bcd_decoder

/* File: bcd_checker.sv */
// Port-level assertion checker for the byte core opcode decoder.
`timescale 1ns/1ps
module bcd_checker #(
  parameter PC_W = 16
) (
  input logic clk,
  input logic rst_b,
  input logic [7:0] prog_data,
  input logic prog_valid,
  input logic [PC_W-1:0] prog_addr,
  input logic prog_req,
  input logic exec_valid,
  input logic [7:0] exec_opcode,
  input logic [1:0] exec_len,
  input logic [2:0] exec_cycles,
  input logic exec_illegal,
  input logic busy
);
  // All checks sample on the rising clock and stay quiet in reset.
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  // An opcode byte accepted while the decoder waits for one.
  sequence s_op_take;
    prog_req && prog_valid && !busy;
  endsequence
  // Fetch held off one more cycle, then resumed.
  sequence s_gap2;
    !prog_req ##1 prog_req;
  endsequence
  // Fetch held off three more cycles, then resumed.
  sequence s_gap4;
    !prog_req [*3] ##1 prog_req;
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_one_byte;
    s_op_take ##0 (prog_data[7:3] == 5'h05) |=> exec_valid && exec_len == 2'h1 && exec_cycles == 3'h1;
  endproperty
  property p_gap1;
    exec_valid && exec_cycles == 3'h1 |-> !prog_req ##1 (prog_req && !exec_valid);
  endproperty
  property p_gap2;
    exec_valid && exec_cycles == 3'h2 |=> s_gap2;
  endproperty
  property p_gap4;
    exec_valid && exec_cycles == 3'h4 |=> s_gap4;
  endproperty
  property p_muldiv;
    exec_valid && (exec_opcode == 8'hA4 || exec_opcode == 8'h84) |-> exec_cycles == 3'h4 && exec_len == 2'h1;
  endproperty
  property p_three;
    exec_valid && exec_opcode inside {8'h53, 8'h43, 8'h63, 8'h85, 8'h75, 8'h90} |-> exec_len == 2'h3 && exec_cycles == 3'h2;
  endproperty
  property p_ext;
    exec_valid && exec_opcode inside {8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3} |-> exec_len == 2'h1 && exec_cycles == 3'h2;
  endproperty
  property p_addr_step;
    prog_req && prog_valid |=> prog_addr == $past(prog_addr) + 1'b1;
  endproperty
  property p_addr_hold;
    !(prog_req && prog_valid) |=> $stable(prog_addr);
  endproperty
  property p_illegal;
    exec_valid && exec_illegal |-> exec_len == 2'h1 && exec_cycles == 3'h1;
  endproperty

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_one_byte: assert property (p_one_byte)
    else $error("register add not decoded as one byte one cycle");
  a_gap1: assert property (p_gap1)
    else $error("one-cycle instruction did not resume fetch");
  a_gap2: assert property (p_gap2)
    else $error("two-cycle instruction held fetch for the wrong time");
  a_gap4: assert property (p_gap4)
    else $error("four-cycle instruction held fetch for the wrong time");
  a_muldiv: assert property (p_muldiv)
    else $error("multiply or divide has wrong length or cycles");
  a_three: assert property (p_three)
    else $error("three-byte instruction has wrong length or cycles");
  a_ext: assert property (p_ext)
    else $error("external data access has wrong length or cycles");
  a_addr_step: assert property (p_addr_step)
    else $error("fetch address did not advance on an accepted byte");
  a_addr_hold: assert property (p_addr_hold)
    else $error("fetch address moved without an accepted byte");
  a_illegal: assert property (p_illegal)
    else $error("unknown opcode not treated as one byte one cycle");
endmodule // bcd_checker

bind bcd_decoder bcd_checker #(.PC_W(PC_W)) u_chk (
  .clk, .rst_b, .prog_data, .prog_valid, .prog_addr, .prog_req, .exec_valid,
  .exec_opcode, .exec_len, .exec_cycles, .exec_illegal, .busy
);

/* File: bcd_prog_mem.sv */
// Program memory model that hands instruction bytes to the decoder.
`timescale 1ns/1ps
module bcd_prog_mem (
  input wire logic clk,
  input wire logic [15:0] prog_addr,
  input wire logic prog_req,
  input wire logic [15:0] avail_end,
  input wire logic slow,
  output logic [7:0] prog_data,
  output logic prog_valid
);
  logic [7:0] mem [0:1023]; // Byte store, filled by the bench.
  logic [7:0] last_q = 8'h00; // Last byte handed over.
  logic ph_q = 1'b0; // Alternating phase for slow answers.

  // A byte is offered only once placed; slow mode offers every other cycle.
  assign prog_valid = (prog_addr < avail_end) && (!slow || ph_q);
  // Between offers the lines carry the inverse of the last byte, so stale data is never seen.
  assign prog_data = prog_valid ? mem[prog_addr[9:0]] : ~last_q;

  // Phase toggle and record of the last accepted byte.
  always @(posedge clk) begin
    ph_q <= ~ph_q;
    if (prog_valid && prog_req) begin
      last_q <= prog_data;
    end
  end
endmodule // bcd_prog_mem

/* File: byte_cpu_opcode_decoder_test.sv */
// Self-checking testbench for the byte core opcode decoder.
`timescale 1ns/1ps
`include "bcd_defs.vh"
module byte_cpu_opcode_decoder_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0; // Held low for the first five cycles.
  logic slow = 1'b0; // Memory answers every other cycle when set.
  logic [15:0] avail_end = 16'h0000; // Bytes below this address are ready.
  logic [15:0] wp = 16'h0000; // Next free program address.
  logic [7:0] prog_data, exec_opcode, exec_operand1, exec_operand2;
  logic [15:0] prog_addr;
  logic prog_valid, prog_req, exec_valid, exec_illegal, busy;
  logic [4:0] exec_class;
  logic [2:0] exec_src, exec_dst, exec_cycles, exec_reg_sel;
  logic [1:0] exec_len;
  int n_fail = 0;
  int check_count = 0;
  int cyc_cnt = 0;

  bcd_decoder #(.PC_W(16)) u_dut (
    .clk, .rst_b, .prog_data, .prog_valid, .prog_addr, .prog_req, .exec_valid, .exec_opcode,
    .exec_class, .exec_src, .exec_dst, .exec_len, .exec_cycles, .exec_reg_sel, .exec_operand1,
    .exec_operand2, .exec_illegal, .busy
  );
  bcd_prog_mem u_mem (.clk, .prog_addr, .prog_req, .avail_end, .slow, .prog_data, .prog_valid);

  // Free-running 200 MHz clock.
  initial begin
    forever #2.5 clk = ~clk;
  end

  // Cuts a hung run short and reports it as a failure.
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      n_fail++;
      final_report;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compares one value and counts the result.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Places one instruction {opcode, 0 illegal len, 0 cycles}, then checks its decode and fetch gap.
  task automatic do_op(input logic [15:0] e);
    logic [7:0] opc;
    int n;
    opc = e[15:8];
    u_mem.mem[wp[9:0]] = opc;
    u_mem.mem[wp[9:0] + 10'h001] = ~opc;
    u_mem.mem[wp[9:0] + 10'h002] = opc ^ 8'h5A;
    wp = wp + {14'h0, e[5:4]};
    avail_end = wp;
    n = 0;
    while (exec_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check("exec_valid", {15'h0, exec_valid}, 16'h0001);
    check("exec_opcode", {8'h0, exec_opcode}, {8'h0, opc});
    check("exec_len", {14'h0, exec_len}, {14'h0, e[5:4]});
    check("exec_cycles", {13'h0, exec_cycles}, {13'h0, e[2:0]});
    check("exec_illegal", {15'h0, exec_illegal}, {15'h0, e[6]});
    check("exec_reg_sel", {13'h0, exec_reg_sel}, {13'h0, opc[2:0]});
    check("exec_operands", {exec_operand1, exec_operand2},
          {(e[5:4] > 2'h1) ? ~opc : 8'h00, (e[5:4] > 2'h2) ? (opc ^ 8'h5A) : 8'h00});
    n = 0;
    while (prog_req === 1'b0 && n < 8) begin
      @(negedge clk);
      n++;
    end
    check("fetch_gap", n[15:0], {13'h0, e[2:0]});
  endtask

  // Runs one instruction, then checks the class, source and destination it holds.
  task automatic do_fld(input logic [15:0] e, input logic [4:0] c, input logic [2:0] s, input logic [2:0] d);
    do_op(e);
    check("exec_class", {11'h0, exec_class}, {11'h0, c});
    check("exec_src_dst", {10'h0, exec_src, exec_dst}, {10'h0, s, d});
  endtask

  // Runs a list of instructions back to back.
  task automatic run_grp(input logic [15:0] v[$]);
    foreach (v[i]) begin
      do_op(v[i]);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Arithmetic forms, both ends of the add register range.
  task automatic t_arith;
    do_fld(16'h2811, `BCD_CLS_ADD, `BCD_SRC_REG, `BCD_DST_ACC);
    run_grp('{16'h2F11, 16'h2521, 16'h2611, 16'h2421});
    do_fld(16'h3421, `BCD_CLS_ADD_CY, `BCD_SRC_IMM, `BCD_DST_ACC);
    run_grp('{16'h3F11, 16'h3521, 16'h3711});
    do_fld(16'h9611, `BCD_CLS_SUB, `BCD_SRC_IND, `BCD_DST_ACC);
    run_grp('{16'h9811, 16'h9521});
    do_fld(16'h8414, `BCD_CLS_DIV, `BCD_SRC_ACC, `BCD_DST_ACC);
    run_grp('{16'hA414, 16'hD411});
  endtask

  // Logical forms into the accumulator and into direct bytes.
  task automatic t_logic;
    run_grp('{16'h5F11, 16'h5521, 16'h5611, 16'h5421});
    do_fld(16'h5332, `BCD_CLS_AND, `BCD_SRC_IMM, `BCD_DST_DIR);
    run_grp('{16'h5221});
    run_grp('{16'h4811, 16'h4521, 16'h4711, 16'h4421});
    run_grp('{16'h4221, 16'h4332});
    run_grp('{16'h6F11, 16'h6521, 16'h6611, 16'h6421});
    run_grp('{16'h6221, 16'h6332});
  endtask

  // Single-byte accumulator operations.
  task automatic t_accum;
    run_grp('{16'h2311, 16'h3311, 16'hE411, 16'hF411, 16'hC411});
    run_grp('{16'h0311, 16'h1311});
  endtask

  // Register, direct and indirect moves.
  task automatic t_moves;
    run_grp('{16'h7821, 16'hFF11});
    run_grp('{16'hA822});
    run_grp('{16'h8F22});
    run_grp('{16'h8532, 16'h7532});
    do_fld(16'hA622, `BCD_CLS_MOVE, `BCD_SRC_DIR, `BCD_DST_IND);
    run_grp('{16'h7721, 16'hF611});
  endtask

  // Pointer, code and external data accesses, then stack and exchange.
  task automatic t_pointer;
    do_fld(16'h9032, `BCD_CLS_PTR_LOAD, `BCD_SRC_IMM, `BCD_DST_PTR);
    run_grp('{16'h9312});
    run_grp('{16'hE012, 16'hF012});
    do_fld(16'hF312, `BCD_CLS_EXT_WRITE, `BCD_SRC_ACC, `BCD_DST_EXT);
    run_grp('{16'hE212});
    do_fld(16'hD022, `BCD_CLS_POP, `BCD_SRC_NONE, `BCD_DST_DIR);
    run_grp('{16'hC022});
    run_grp('{16'hC811, 16'hC521, 16'hC711});
  endtask

  // Unknown opcode, subtract immediate and no-op.
  task automatic t_odd;
    do_fld(16'hA551, `BCD_CLS_ILLEGAL, `BCD_SRC_NONE, `BCD_DST_ACC);
    run_grp('{16'h9421, 16'h0011});
  endtask

  // Slow memory stretching multi-byte fetches.
  task automatic t_slow;
    slow = 1'b1;
    run_grp('{16'h5332, 16'h9032, 16'hA822, 16'hE012, 16'h2F11});
    slow = 1'b0;
  endtask

  // Reset in the middle of a three-byte fetch, then a clean restart.
  task automatic t_reset;
    u_mem.mem[wp[9:0]] = 8'h75;
    avail_end = wp + 16'h0002;
    repeat (4) @(negedge clk);
    rst_b = 1'b0;
    #1;
    check("reset_addr", prog_addr, 16'h0000);
    check("reset_req_busy_valid", {13'h0, prog_req, busy, exec_valid}, 16'h0004);
    check("reset_len_cycles", {11'h0, exec_len, exec_cycles}, 16'h0009);
    wp = 16'h0000;
    avail_end = 16'h0000;
    @(negedge clk);
    rst_b = 1'b1;
    do_op(16'h7532);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    t_arith;
    t_logic;
    t_accum;
    t_moves;
    t_pointer;
    t_odd;
    t_slow;
    t_reset;
    final_report;
  end
endmodule // byte_cpu_opcode_decoder_test
